/* rtl/esc_pkg.sv */
// Constants, register map and carrier types of the E1 signalling conditioning block.
// Assumes one 200 MHz clock domain shared by the framer, packet buffer and APB.
`default_nettype none

package esc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_IDLE      = 8'h04;
  localparam logic [7:0] ADDR_COND_DATA = 8'h08;
  localparam logic [7:0] ADDR_COND_ABCD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // CTRL field positions
  localparam int CTRL_LINE_LSB   = 0;
  localparam int CTRL_CAS_BIT    = 2;
  localparam int CTRL_PKT_EN_BIT = 4;
  localparam int CTRL_LIN_EN_BIT = 5;

  // Interrupt bit positions
  localparam int IRQ_RX_ALARM = 0;
  localparam int IRQ_TX_FAULT = 1;
  localparam int IRQ_RESUME   = 2;
  localparam int IRQ_W        = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Line type and operation mode encodings
  typedef enum logic [1:0] {
    ESC_LINE_UNFRAMED = 2'h0,
    ESC_LINE_CRC4_ON  = 2'h1,
    ESC_LINE_CRC4_OFF = 2'h2
  } esc_line_type;

  typedef enum logic [1:0] {
    ESC_OP_TRANSPARENT = 2'h0,
    ESC_OP_FRACTIONAL  = 2'h1,
    ESC_OP_FRAC_CAS    = 2'h2
  } esc_op_mode_type;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset, the illegal ABCD code and the AIS fill byte
  localparam esc_line_type  RST_LINE      = ESC_LINE_CRC4_ON;
  localparam logic          RST_CAS_EN    = 1'b1;
  localparam logic [7:0]    RST_IDLE      = 8'h7e;
  localparam logic [7:0]    RST_COND_DATA = 8'hff;
  localparam logic [3:0]    RST_COND_ABCD = 4'h1;
  localparam logic [3:0]    ABCD_ILLEGAL  = 4'h0;
  localparam logic [7:0]    AIS_BYTE      = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // One timeslot beat: byte, its ABCD bits, and whether the slot is assigned
  typedef struct packed {
    logic       valid;
    logic       used;
    logic [7:0] data;
    logic [3:0] abcd;
  } esc_beat_type;

  // Framer set-up driven from the configuration
  typedef struct packed {
    logic            cas_mf;
    logic            crc4_mf;
    logic            pass_thru;
    esc_op_mode_type op_mode;
  } esc_framer_type;

endpackage : esc_pkg

`default_nettype wire

/* rtl/esc_top.sv */
// E1 signalling mode control and conditioning-pattern substitution, with APB registers.
// Assumes framer alarms, framer beats and packet buffer flags are on clk_i already.
//
// What this block does
// - CAS enabled: framer in CAS multiframe, operation fractional with CAS.
// - CAS disabled: no CAS multiframe, operation plain fractional.
// - After reset the signalling mode reads CAS enabled.
// - Unframed line type ignores the signalling mode; it reads back as zero.
// - Line LOS, LOF or AIS replaces bytes toward packets with conditioning byte, default FF.
// - Buffer overrun or underrun fills bytes toward the line with conditioning byte.
// - Unframed: LOS or buffer fault sends AIS instead of a pattern.
// - CAS enabled: line alarm sends ABCD conditioning code toward packets; range 1 to F, default 1.
// - CAS enabled: buffer overrun or underrun applies ABCD conditioning code toward the line.
// - Unframed: conditioning byte and ABCD code unused and read as zero.
// - Unframed: framer pass-through, transparent operation, no slot or signalling work.
// - Framed: unused slots toward the line carry the idle code, default 7E.
`default_nettype none

module esc_top (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  output logic                        irq_o,
  // Line alarms from the E1 receiver
  input  wire logic                   los_i,
  input  wire logic                   lof_i,
  input  wire logic                   ais_i,
  // Packet receive buffer faults
  input  wire logic                   buf_overrun_i,
  input  wire logic                   buf_underrun_i,
  // Beats from the line toward packets, and from packets toward the line
  input  wire esc_pkg::esc_beat_type  rx_beat_i,
  input  wire esc_pkg::esc_beat_type  tx_beat_i,
  output esc_pkg::esc_beat_type       pkt_beat_o,
  output logic                        pkt_ais_o,
  output esc_pkg::esc_beat_type       line_beat_o,
  output logic                        line_ais_o,
  output esc_pkg::esc_framer_type     framer_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
    esc_pkg::esc_line_type   line_type;
    logic                    cas_en;
    logic                    pkt_cond_en;
    logic                    line_cond_en;
    logic [7:0]              idle;
    logic [7:0]              cond_data;
    logic [3:0]              cond_abcd;
    logic [esc_pkg::IRQ_W-1:0] int_stat;
    logic [esc_pkg::IRQ_W-1:0] int_mask;
    logic                    rx_cond_q;
    logic                    tx_cond_q;
    esc_pkg::esc_beat_type   pkt_beat;
    logic                    pkt_ais;
    esc_pkg::esc_beat_type   line_beat;
    logic                    line_ais;
    esc_pkg::esc_framer_type framer;
  } esc_state_type;

  esc_state_type state;
  esc_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational terms
  logic                    unframed;
  logic                    rx_alarm;
  logic                    buf_fault;
  logic                    rx_cond;
  logic                    tx_cond;
  logic                    setup;
  logic                    wr_commit;
  logic                    addr_ok;
  logic [31:0]             rd_val;
  logic [31:0]             ctrl_val;
  logic [esc_pkg::IRQ_W-1:0] events;
  logic [esc_pkg::IRQ_W-1:0] w1c;

  assign unframed  = (state.line_type == esc_pkg::ESC_LINE_UNFRAMED);
  // Framed: any alarm conditions; unframed: only LOS leads to AIS
  assign rx_alarm  = unframed ? los_i : (los_i | lof_i | ais_i);
  assign buf_fault = buf_overrun_i | buf_underrun_i;
  assign rx_cond   = rx_alarm & (unframed | state.pkt_cond_en);
  assign tx_cond   = buf_fault & (unframed | state.line_cond_en);
  assign setup     = psel_i & ~penable_i;
  assign wr_commit = psel_i & penable_i & state.pready & pwrite_i;

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr_i)
      esc_pkg::ADDR_CTRL, esc_pkg::ADDR_IDLE, esc_pkg::ADDR_COND_DATA,
      esc_pkg::ADDR_COND_ABCD, esc_pkg::ADDR_STATUS, esc_pkg::ADDR_INT_STAT,
      esc_pkg::ADDR_INT_MASK: addr_ok = 1'b1;
      default:                addr_ok = 1'b0;
    endcase
  end

  // Signalling mode reads as zero while unframed since it has no meaning
  always_comb begin
    ctrl_val = 32'h0;
    ctrl_val[esc_pkg::CTRL_LINE_LSB +: 2] = state.line_type;
    ctrl_val[esc_pkg::CTRL_CAS_BIT]       = state.cas_en & ~unframed;
    ctrl_val[esc_pkg::CTRL_PKT_EN_BIT]    = state.pkt_cond_en;
    ctrl_val[esc_pkg::CTRL_LIN_EN_BIT]    = state.line_cond_en;
  end

  always_comb begin
    rd_val = 32'h0;
    unique case (paddr_i)
      esc_pkg::ADDR_CTRL:      rd_val = ctrl_val;
      esc_pkg::ADDR_IDLE:      rd_val[7:0] = unframed ? 8'h00 : state.idle;
      esc_pkg::ADDR_COND_DATA: rd_val[7:0] = unframed ? 8'h00 : state.cond_data;
      esc_pkg::ADDR_COND_ABCD: rd_val[3:0] = unframed ? 4'h0 : state.cond_abcd;
      esc_pkg::ADDR_STATUS:    rd_val[7:0] = {state.framer.op_mode, state.framer.pass_thru,
                                              state.line_ais, state.pkt_ais,
                                              state.tx_cond_q, state.rx_cond_q, buf_fault};
      esc_pkg::ADDR_INT_STAT:  rd_val[esc_pkg::IRQ_W-1:0] = state.int_stat;
      esc_pkg::ADDR_INT_MASK:  rd_val[esc_pkg::IRQ_W-1:0] = state.int_mask;
      default:                 rd_val = 32'h0;
    endcase
  end

  always_comb begin
    events = '0;
    events[esc_pkg::IRQ_RX_ALARM] = rx_cond & ~state.rx_cond_q;
    events[esc_pkg::IRQ_TX_FAULT] = tx_cond & ~state.tx_cond_q;
    events[esc_pkg::IRQ_RESUME]   = (state.rx_cond_q & ~rx_cond) | (state.tx_cond_q & ~tx_cond);
    w1c = '0;
    if (wr_commit && paddr_i == esc_pkg::ADDR_INT_STAT) begin
      w1c = pwdata_i[esc_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;

    // APB: setup cycle prepares the answer, access phase completes at once
    next_state.pready  = setup;
    next_state.pslverr = setup & ~addr_ok;
    if (setup && !pwrite_i) begin
      next_state.prdata = rd_val;
    end

    if (wr_commit) begin
      unique case (paddr_i)
        esc_pkg::ADDR_CTRL: begin
          if (pwdata_i[esc_pkg::CTRL_LINE_LSB +: 2] != 2'h3) begin
            next_state.line_type =
              esc_pkg::esc_line_type'(pwdata_i[esc_pkg::CTRL_LINE_LSB +: 2]);
          end
          // Mode bit not offered while unframed, so a write then leaves it alone
          if (!unframed) begin
            next_state.cas_en = pwdata_i[esc_pkg::CTRL_CAS_BIT];
          end
          next_state.pkt_cond_en  = pwdata_i[esc_pkg::CTRL_PKT_EN_BIT];
          next_state.line_cond_en = pwdata_i[esc_pkg::CTRL_LIN_EN_BIT];
        end
        esc_pkg::ADDR_IDLE: begin
          if (!unframed) next_state.idle = pwdata_i[7:0];
        end
        esc_pkg::ADDR_COND_DATA: begin
          if (!unframed) next_state.cond_data = pwdata_i[7:0];
        end
        esc_pkg::ADDR_COND_ABCD: begin
          // Code zero is outside the range and is ignored
          if (!unframed && pwdata_i[3:0] != esc_pkg::ABCD_ILLEGAL) begin
            next_state.cond_abcd = pwdata_i[3:0];
          end
        end
        esc_pkg::ADDR_INT_MASK: next_state.int_mask = pwdata_i[esc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // Sticky status: a new event wins over a write-one clear
    next_state.int_stat = (state.int_stat & ~w1c) | events;
    next_state.irq      = |(next_state.int_stat & next_state.int_mask);
    next_state.rx_cond_q = rx_cond;
    next_state.tx_cond_q = tx_cond;

    // Framer set-up from line type and signalling mode
    if (unframed) begin
      next_state.framer.pass_thru = 1'b1;
      next_state.framer.cas_mf    = 1'b0;
      next_state.framer.crc4_mf   = 1'b0;
      next_state.framer.op_mode   = esc_pkg::ESC_OP_TRANSPARENT;
    end else begin
      next_state.framer.pass_thru = 1'b0;
      next_state.framer.crc4_mf   = (state.line_type == esc_pkg::ESC_LINE_CRC4_ON);
      next_state.framer.cas_mf    = state.cas_en;
      next_state.framer.op_mode   = state.cas_en ? esc_pkg::ESC_OP_FRAC_CAS
                                                 : esc_pkg::ESC_OP_FRACTIONAL;
    end

    // Toward the packet side; live data returns as soon as the alarm clears
    next_state.pkt_beat = rx_beat_i;
    next_state.pkt_ais  = 1'b0;
    if (unframed) begin
      if (rx_cond) begin
        next_state.pkt_beat.data = esc_pkg::AIS_BYTE;
        next_state.pkt_ais       = 1'b1;
      end
    end else if (rx_cond) begin
      next_state.pkt_beat.data = state.cond_data;
      if (state.cas_en) next_state.pkt_beat.abcd = state.cond_abcd;
    end

    // Toward the E1 line
    next_state.line_beat = tx_beat_i;
    next_state.line_ais  = 1'b0;
    if (unframed) begin
      if (tx_cond) begin
        next_state.line_beat.data = esc_pkg::AIS_BYTE;
        next_state.line_ais       = 1'b1;
      end
    end else if (!tx_beat_i.used) begin
      next_state.line_beat.data = state.idle;
    end else if (tx_cond) begin
      next_state.line_beat.data = state.cond_data;
      if (state.cas_en) next_state.line_beat.abcd = state.cond_abcd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                  <= '0;
      state.line_type        <= esc_pkg::RST_LINE;
      state.cas_en           <= esc_pkg::RST_CAS_EN;
      state.pkt_cond_en      <= 1'b1;
      state.line_cond_en     <= 1'b1;
      state.idle             <= esc_pkg::RST_IDLE;
      state.cond_data        <= esc_pkg::RST_COND_DATA;
      state.cond_abcd        <= esc_pkg::RST_COND_ABCD;
      state.framer.cas_mf    <= esc_pkg::RST_CAS_EN;
      state.framer.crc4_mf   <= 1'b1;
      state.framer.op_mode   <= esc_pkg::ESC_OP_FRAC_CAS;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata_o    = state.prdata;
  assign pready_o    = state.pready;
  assign pslverr_o   = state.pslverr;
  assign irq_o       = state.irq;
  assign pkt_beat_o  = state.pkt_beat;
  assign pkt_ais_o   = state.pkt_ais;
  assign line_beat_o = state.line_beat;
  assign line_ais_o  = state.line_ais;
  assign framer_o    = state.framer;

endmodule // esc_top

`default_nettype wire

/* dv/esc_pbx_model.sv */
// Line equipment model: a changing beat toward the block, AIS cycles counted.
// Assumes it shares clk_i and reset_n_i with the block.
`default_nettype none
module esc_pbx_model (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             line_ais_i,
  output esc_pkg::esc_beat_type rx_beat_o,
  output logic [31:0]           ais_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data and ABCD move every beat so a stale path cannot match
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_beat_o  <= '0;
      ais_seen_o <= '0;
    end else begin
      rx_beat_o  <= {1'b1, 1'b1, rx_beat_o.data + 8'h35, rx_beat_o.abcd + 4'h3};
      ais_seen_o <= ais_seen_o + 32'(line_ais_i);
    end
  end
endmodule // esc_pbx_model
`default_nettype wire

/* dv/esc_monitor.sv */
// Port checker for the conditioning block.
// Assumes one clock domain with reset_n_i async, active low.
`default_nettype none
module esc_mon (
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic [7:0]              paddr_i,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  input wire logic                    los_i,
  input wire logic                    lof_i,
  input wire logic                    ais_i,
  input wire logic                    buf_overrun_i,
  input wire logic                    buf_underrun_i,
  input wire esc_pkg::esc_beat_type   rx_beat_i,
  input wire esc_pkg::esc_beat_type   tx_beat_i,
  input wire esc_pkg::esc_beat_type   pkt_beat_o,
  input wire logic                    pkt_ais_o,
  input wire esc_pkg::esc_beat_type   line_beat_o,
  input wire logic                    line_ais_o,
  input wire esc_pkg::esc_framer_type framer_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx_alarm;
  logic buf_fault;
  assign rx_alarm  = los_i | lof_i | ais_i;
  assign buf_fault = buf_overrun_i | buf_underrun_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_bad_access;
    psel_i && penable_i && pready_o && paddr_i > 8'h18;
  endsequence
  AST_APB_READY: assert property (s_setup |=> pready_o)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready wider than one cycle");
  AST_PSLVERR: assert property (s_bad_access |-> pslverr_o)
    else $error("unmapped access without error");
  AST_CAS_ON: assert property (framer_o.op_mode == esc_pkg::ESC_OP_FRAC_CAS
    |-> framer_o.cas_mf && !framer_o.pass_thru) else $error("cas mode mismatch");
  AST_CAS_OFF: assert property (framer_o.op_mode == esc_pkg::ESC_OP_FRACTIONAL
    |-> !framer_o.cas_mf && !framer_o.pass_thru) else $error("fractional mismatch");
  AST_TRANSP: assert property (framer_o.pass_thru
    |-> framer_o.op_mode == esc_pkg::ESC_OP_TRANSPARENT && !framer_o.cas_mf)
    else $error("pass-through mismatch");
  AST_PKT_LIVE: assert property (!rx_alarm |=> pkt_beat_o == $past(rx_beat_i))
    else $error("packet beat not live");
  AST_LINE_LIVE: assert property (!buf_fault && tx_beat_i.used
    |=> line_beat_o == $past(tx_beat_i)) else $error("line beat not live");
  // Pass-through lags the line type by one cycle, so it confirms unframed at the alarm
  sequence s_los_unframed;
    los_i ##1 framer_o.pass_thru;
  endsequence
  sequence s_fault_unframed;
    buf_fault ##1 framer_o.pass_thru;
  endsequence
  AST_AIS_PKT: assert property (s_los_unframed
    |-> pkt_ais_o && pkt_beat_o.data == esc_pkg::AIS_BYTE) else $error("no packet ais");
  AST_AIS_LINE: assert property (s_fault_unframed
    |-> line_ais_o && line_beat_o.data == esc_pkg::AIS_BYTE) else $error("no line ais");
  AST_AIS_END: assert property (!los_i && !buf_fault |=> !pkt_ais_o && !line_ais_o)
    else $error("ais without cause");
endmodule // esc_mon
bind esc_top esc_mon u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .los_i(los_i),
  .lof_i(lof_i), .ais_i(ais_i), .buf_overrun_i(buf_overrun_i),
  .buf_underrun_i(buf_underrun_i), .rx_beat_i(rx_beat_i), .tx_beat_i(tx_beat_i),
  .pkt_beat_o(pkt_beat_o), .pkt_ais_o(pkt_ais_o), .line_beat_o(line_beat_o),
  .line_ais_o(line_ais_o), .framer_o(framer_o));
`default_nettype wire

/* dv/esc_tb.sv */
// Self-checking bench for the conditioning block over APB.
// Assumes the package, the block, the line model and the checker.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, rerr, irq_o;
  logic        pready_o, pslverr_o, pkt_ais_o, line_ais_o;
  logic        los_i, lof_i, ais_i, buf_overrun_i, buf_underrun_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat, ais_seen;
  int          num_errors, cmp_count;
  esc_pkg::esc_beat_type   rx_beat, tx_beat, pkt_beat_o, line_beat_o, pv, ov;
  esc_pkg::esc_framer_type framer_o;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h35, 32'h7e, 32'hff, 32'h1, 32'h80, 32'h0, 32'h0, 32'h0};

  esc_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .los_i(los_i), .lof_i(lof_i),
    .ais_i(ais_i), .buf_overrun_i(buf_overrun_i), .buf_underrun_i(buf_underrun_i),
    .rx_beat_i(rx_beat), .tx_beat_i(tx_beat), .pkt_beat_o(pkt_beat_o), .pkt_ais_o(pkt_ais_o),
    .line_beat_o(line_beat_o), .line_ais_o(line_ais_o), .framer_o(framer_o));
  esc_pbx_model u_pbx (.clk_i(clk_i), .reset_n_i(reset_n_i), .line_ais_i(line_ais_o),
    .rx_beat_o(rx_beat), .ais_seen_o(ais_seen));

  always #2.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic alarms(input logic [4:0] v);
    @(posedge clk_i);
    {buf_underrun_i, buf_overrun_i, ais_i, lof_i, los_i} <= v;
  endtask
  // Live value is what the block sampled at the same edge
  task automatic beat_chk(input logic ln, input logic sd, input logic [7:0] ed);
    @(posedge clk_i);
    pv = ln ? tx_beat : rx_beat;
    #1;
    ov = ln ? line_beat_o : pkt_beat_o;
    check("beat data", 32'(ov.data), 32'(sd ? ed : pv.data));
  endtask
  task automatic fr_chk(input logic [4:0] e);
    repeat (2) @(posedge clk_i);
    #1;
    check("framer", 32'(framer_o), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_i, reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {los_i, lof_i, ais_i, buf_overrun_i, buf_underrun_i} = '0;
    tx_beat = '0;
    num_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    fr_chk(5'h1a);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", rdat, rv[i]);
      check("slave error", 32'(rerr), 32'(i == 7));
    end
    apb(1'b1, esc_pkg::ADDR_COND_DATA, 32'ha5);
    apb(1'b1, esc_pkg::ADDR_COND_ABCD, 32'h9);
    apb(1'b1, esc_pkg::ADDR_COND_ABCD, 32'h0);
    apb(1'b0, esc_pkg::ADDR_COND_ABCD, 32'h0);
    check("abcd zero", rdat, 32'h9);
    apb(1'b1, esc_pkg::ADDR_INT_MASK, 32'h7);
    for (int k = 0; k < 3; k++) begin
      alarms(5'(1 << k));
      beat_chk(1'b0, 1'b1, 8'ha5);
      check("pkt abcd", 32'(ov.abcd), 32'h9);
      alarms(5'h0);
      beat_chk(1'b0, 1'b0, 8'h0);
    end
    check("irq set", 32'(irq_o), 32'h1);
    apb(1'b1, esc_pkg::ADDR_INT_STAT, 32'h7);
    apb(1'b1, esc_pkg::ADDR_INT_MASK, 32'h0);
    alarms(5'h1);
    apb(1'b0, esc_pkg::ADDR_INT_STAT, 32'h0);
    check("stat masked", rdat, 32'h1);
    check("irq masked", 32'(irq_o), 32'h0);
    alarms(5'h0);
    @(posedge clk_i);
    tx_beat <= {1'b1, 1'b1, 8'h5a, 4'h6};
    for (int k = 3; k < 5; k++) begin
      alarms(5'(1 << k));
      beat_chk(1'b1, 1'b1, 8'ha5);
      check("line abcd", 32'(ov.abcd), 32'h9);
    end
    alarms(5'h0);
    beat_chk(1'b1, 1'b0, 8'h0);
    @(posedge clk_i);
    tx_beat.used <= 1'b0;
    beat_chk(1'b1, 1'b1, 8'h7e);
    apb(1'b1, esc_pkg::ADDR_CTRL, 32'h31);
    fr_chk(5'h09);
    alarms(5'h1);
    beat_chk(1'b0, 1'b1, 8'ha5);
    check("pkt abcd", 32'(ov.abcd), 32'(pv.abcd));
    alarms(5'h0);
    apb(1'b1, esc_pkg::ADDR_CTRL, 32'h30);
    fr_chk(5'h04);
    apb(1'b1, esc_pkg::ADDR_CTRL, 32'h34);
    apb(1'b0, esc_pkg::ADDR_CTRL, 32'h0);
    check("ctrl unframed", rdat, 32'h30);
    apb(1'b0, esc_pkg::ADDR_COND_DATA, 32'h0);
    check("cond unframed", rdat, 32'h0);
    alarms(5'h1);
    beat_chk(1'b0, 1'b1, 8'hff);
    check("pkt ais", 32'(pkt_ais_o), 32'h1);
    alarms(5'h8);
    beat_chk(1'b1, 1'b1, 8'hff);
    check("line ais", 32'(line_ais_o), 32'h1);
    alarms(5'h0);
    beat_chk(1'b1, 1'b0, 8'h0);
    check("ais at line", 32'(ais_seen != 32'h0), 32'h1);
    apb(1'b1, esc_pkg::ADDR_CTRL, 32'h35);
    fr_chk(5'h09);
    apb(1'b1, esc_pkg::ADDR_CTRL, 32'h36);
    fr_chk(5'h12);
    close_out();
  end

  // Cut a hang short after about 5000 cycles
  initial begin
    #25000;
    num_errors++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
